// *** src/mmrv_pkg.sv ***
// package: memory map, vector slots and region codes for the address decoder
package mmrv_pkg;
    localparam int          MMRV_ADDR_W      = 16;
    localparam int          MMRV_DATA_W      = 8;
    localparam logic [15:0] MMRV_VEC_BASE    = 16'h0000;
    localparam logic [15:0] MMRV_VEC_LAST    = 16'h0013;
    localparam logic [15:0] MMRV_VEC_RESET   = 16'h0000;
    localparam logic [15:0] MMRV_VEC_RESET_H = 16'h0001;
    localparam logic [15:0] MMRV_VEC_LVD     = 16'h0006;
    localparam logic [15:0] MMRV_VEC_EXT0    = 16'h0008;
    localparam logic [15:0] MMRV_VEC_EXT1    = 16'h000A;
    localparam logic [15:0] MMRV_VEC_TMR8    = 16'h000C;
    localparam logic [15:0] MMRV_VEC_TMRA    = 16'h000E;
    localparam logic [15:0] MMRV_VEC_TMRB    = 16'h0010;
    localparam logic [15:0] MMRV_VEC_ADC     = 16'h0012;
    localparam logic [15:0] MMRV_TCALL_BASE  = 16'h0040;
    localparam logic [15:0] MMRV_TCALL_LAST  = 16'h007F;
    localparam logic [15:0] MMRV_OPTION_ADDR = 16'h0080;
    localparam logic [15:0] MMRV_PROTECT_ADR = 16'h0081;
    localparam logic [15:0] MMRV_FLASH_1K    = 16'h0400;
    localparam logic [15:0] MMRV_FLASH_2K    = 16'h0800;
    localparam logic [15:0] MMRV_FLASH_4K    = 16'h1000;
    localparam logic [15:0] MMRV_RAM_BASE    = 16'hFE80;
    localparam logic [15:0] MMRV_RAM_LAST    = 16'hFEFF;
    localparam logic [15:0] MMRV_SFR_BASE    = 16'hFF00;
    localparam logic [15:0] MMRV_SFR_LAST    = 16'hFFFF;
    localparam logic [15:0] MMRV_PC_RESET    = 16'h0000;
    localparam logic [7:0]  MMRV_BYTE_ZERO   = 8'h00;
    localparam logic [15:0] MMRV_ONE         = 16'h0001;

    typedef enum logic [2:0] {
        MMRV_REG_FLASH,
        MMRV_REG_PROHIBITED,
        MMRV_REG_RAM,
        MMRV_REG_SFR
    } mmrv_region_e;

    typedef enum logic [2:0] {
        MMRV_AREA_VECTOR,
        MMRV_AREA_TCALL,
        MMRV_AREA_OPTION,
        MMRV_AREA_PROTECT,
        MMRV_AREA_PROGRAM,
        MMRV_AREA_NONE
    } mmrv_area_e;
endpackage : mmrv_pkg

// *** src/mmrv_decode.sv ***
// address decoder: region and program-area classification of one address
module mmrv_decode
    import mmrv_pkg::*;
#(
    parameter logic [15:0] FLASH_SIZE = MMRV_FLASH_2K
) (
    input  wire logic [15:0] addr,
    output mmrv_region_e     region,
    output mmrv_area_e       area
);
    always_comb begin
        if (addr >= MMRV_SFR_BASE) begin
            region = MMRV_REG_SFR; // RQ11
        end else if (addr >= MMRV_RAM_BASE) begin
            region = MMRV_REG_RAM; // RQ10
        end else if (addr < FLASH_SIZE) begin
            region = MMRV_REG_FLASH; // RQ8
        end else begin
            region = MMRV_REG_PROHIBITED; // RQ9
        end
    end

    always_comb begin
        if (addr >= FLASH_SIZE) begin
            area = MMRV_AREA_NONE;
        end else if (addr <= MMRV_VEC_LAST) begin
            area = MMRV_AREA_VECTOR; // RQ2
        end else if (addr >= MMRV_TCALL_BASE && addr <= MMRV_TCALL_LAST) begin
            area = MMRV_AREA_TCALL; // RQ5
        end else if (addr == MMRV_OPTION_ADDR) begin
            area = MMRV_AREA_OPTION; // RQ6
        end else if (addr == MMRV_PROTECT_ADR) begin
            area = MMRV_AREA_PROTECT; // RQ7
        end else begin
            area = MMRV_AREA_PROGRAM;
        end
    end
endmodule : mmrv_decode

// *** src/mmrv_memory_map.sv ***
// memory map, program counter and reset-vector load for the 8-bit core
// Operation
// RQ1: one flat 64 KB space with 16-bit addresses serves program and data accesses.
// RQ2: bytes 0000H to 0013H of flash hold the reset and interrupt start addresses.
// RQ3: a vector is read low byte from the even address, high byte from the next odd one.
// RQ4: slots are reset 0000H, low voltage 0006H, ext 0008H/000AH, timers 000CH-0010H, adc 0012H.
// RQ5: table-call entry addresses are fetched from 0040H to 007FH.
// RQ6: the option byte lives alone at 0080H.
// RQ7: the protect byte lives alone at 0081H.
// RQ8: flash starts at zero, sized 1024, 2048 or 4096 bytes, and the decoder follows it.
// RQ9: in the 2048-byte part, 0800H to FE7FH is a prohibited region.
// RQ10: 128 bytes of RAM at FE80H to FEFFH, also used as stack.
// RQ11: peripheral registers are decoded in FF00H to FFFFH.
// RQ12: the program counter is 16 bits and holds the next fetch address.
// RQ13: in sequence the counter advances by the fetched instruction length.
// RQ14: a branch loads the counter from an immediate or a register value.
// RQ15: on reset the counter is loaded from 0000H (low) and 0001H (high).
// RQ16: the outside system asserts reset by driving the reset pin low.
// RQ17: fetching holds while reset is low; the vector load follows release.
module mmrv_memory_map
    import mmrv_pkg::*;
#(
    parameter logic [15:0] FLASH_SIZE = MMRV_FLASH_2K
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        reset_pin_n,
    // core side
    input  wire logic        core_advance,
    input  wire logic [2:0]  core_instr_len,
    input  wire logic        core_branch,
    input  wire logic        core_branch_sel_reg,
    input  wire logic [15:0] core_branch_imm,
    input  wire logic [15:0] core_branch_reg,
    input  wire logic        core_vector_req,
    input  wire logic [15:0] core_vector_addr,
    input  wire logic        core_data_req,
    input  wire logic [15:0] core_data_addr,
    // memory side: program flash read
    output logic [15:0]      flash_addr_q,
    output logic             flash_rd_q,
    input  wire logic [7:0]  flash_rdata,
    // results
    output logic [15:0]      pc_q,
    output logic             fetch_enable_q,
    output logic             vector_valid_q,
    output logic [15:0]      vector_value_q,
    output logic             data_sel_flash_q,
    output logic             data_sel_ram_q,
    output logic             data_sel_sfr_q,
    output logic             data_prohibited_q,
    output logic             data_option_q,
    output logic             data_protect_q,
    output logic             data_tcall_q
);
    typedef enum logic [2:0] {
        MMRV_ST_HOLD,
        MMRV_ST_VLO,
        MMRV_ST_VCAP,
        MMRV_ST_VHI,
        MMRV_ST_RUN,
        MMRV_ST_IVLO,
        MMRV_ST_IVCAP,
        MMRV_ST_IVHI
    } mmrv_state_e;

    mmrv_state_e  state_q;
    logic         rst_meta_q;
    logic         rst_sync_q;
    logic [7:0]   vec_lo_q;
    logic [15:0]  vec_base_q;
    mmrv_region_e data_region;
    mmrv_area_e   data_area;
    logic [15:0]  len_ext;

    assign len_ext = {13'h0000, core_instr_len};

    // pin level crosses in through two flops before the state machine sees it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= reset_pin_n;
            rst_sync_q <= rst_meta_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || !rst_sync_q) begin
            state_q <= MMRV_ST_HOLD; // RQ16 RQ17
        end else begin
            case (state_q)
                MMRV_ST_HOLD: state_q <= MMRV_ST_VLO; // RQ17
                MMRV_ST_VLO:  state_q <= MMRV_ST_VCAP;
                MMRV_ST_VCAP: state_q <= MMRV_ST_VHI;
                MMRV_ST_VHI:  state_q <= MMRV_ST_RUN;
                MMRV_ST_RUN: begin
                    if (core_vector_req) begin
                        state_q <= MMRV_ST_IVLO;
                    end
                end
                MMRV_ST_IVLO:  state_q <= MMRV_ST_IVCAP;
                MMRV_ST_IVCAP: state_q <= MMRV_ST_IVHI;
                MMRV_ST_IVHI: state_q <= MMRV_ST_RUN;
                default:      state_q <= MMRV_ST_HOLD;
            endcase
        end
    end

    // vector slot address, even-aligned; a non-slot request is forced to its even byte
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vec_base_q <= MMRV_VEC_RESET;
        end else if (state_q == MMRV_ST_HOLD) begin
            vec_base_q <= MMRV_VEC_RESET; // RQ15
        end else if (state_q == MMRV_ST_RUN && core_vector_req) begin
            vec_base_q <= {core_vector_addr[15:1], 1'b0}; // RQ3 RQ4
        end
    end

    // flash read address: low byte at even, high byte at following odd
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flash_addr_q <= MMRV_VEC_RESET;
            flash_rd_q   <= 1'b0;
        end else begin
            case (state_q)
                MMRV_ST_HOLD: begin
                    flash_addr_q <= MMRV_VEC_RESET; // RQ15
                    flash_rd_q   <= 1'b0;
                end
                MMRV_ST_VLO: begin
                    flash_addr_q <= MMRV_VEC_RESET_H; // RQ15
                    flash_rd_q   <= 1'b1;
                end
                MMRV_ST_RUN: begin
                    flash_addr_q <= core_vector_req ? {core_vector_addr[15:1], 1'b0} : pc_q;
                    flash_rd_q   <= 1'b1;
                end
                MMRV_ST_IVLO: begin
                    flash_addr_q <= vec_base_q | MMRV_ONE; // RQ3
                    flash_rd_q   <= 1'b1;
                end
                default: begin
                    flash_addr_q <= pc_q;
                    flash_rd_q   <= 1'b1;
                end
            endcase
        end
    end

    // address flop plus synchronous flash: a byte shows two edges after its address,
    // so low byte is caught in the capture state, high byte one edge later
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vec_lo_q <= MMRV_BYTE_ZERO;
        end else if (state_q == MMRV_ST_VCAP || state_q == MMRV_ST_IVCAP) begin
            vec_lo_q <= flash_rdata; // RQ3
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pc_q <= MMRV_PC_RESET;
        end else if (state_q == MMRV_ST_HOLD) begin
            pc_q <= MMRV_PC_RESET;
        end else if (state_q == MMRV_ST_VHI || state_q == MMRV_ST_IVHI) begin
            pc_q <= {flash_rdata, vec_lo_q}; // RQ15 RQ3 RQ12
        end else if (state_q == MMRV_ST_RUN && !core_vector_req) begin
            if (core_branch) begin
                pc_q <= core_branch_sel_reg ? core_branch_reg : core_branch_imm; // RQ14
            end else if (core_advance) begin
                pc_q <= pc_q + len_ext; // RQ13
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fetch_enable_q <= 1'b0;
            vector_valid_q <= 1'b0;
            vector_value_q <= MMRV_PC_RESET;
        end else begin
            fetch_enable_q <= (state_q == MMRV_ST_RUN) && !core_vector_req; // RQ17
            vector_valid_q <= (state_q == MMRV_ST_VHI) || (state_q == MMRV_ST_IVHI);
            if (state_q == MMRV_ST_VHI || state_q == MMRV_ST_IVHI) begin
                vector_value_q <= {flash_rdata, vec_lo_q}; // RQ3
            end
        end
    end

    mmrv_decode #(
        .FLASH_SIZE (FLASH_SIZE)
    ) u_data_decode (
        .addr   (core_data_addr),
        .region (data_region),
        .area   (data_area)
    );

    // one flat 16-bit map for program and data accesses
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_sel_flash_q  <= 1'b0;
            data_sel_ram_q    <= 1'b0;
            data_sel_sfr_q    <= 1'b0;
            data_prohibited_q <= 1'b0;
            data_option_q     <= 1'b0;
            data_protect_q    <= 1'b0;
            data_tcall_q      <= 1'b0;
        end else begin
            data_sel_flash_q  <= core_data_req && (data_region == MMRV_REG_FLASH); // RQ1 RQ8
            data_sel_ram_q    <= core_data_req && (data_region == MMRV_REG_RAM); // RQ10
            data_sel_sfr_q    <= core_data_req && (data_region == MMRV_REG_SFR); // RQ11
            data_prohibited_q <= core_data_req && (data_region == MMRV_REG_PROHIBITED); // RQ9
            data_option_q     <= core_data_req && (data_area == MMRV_AREA_OPTION); // RQ6
            data_protect_q    <= core_data_req && (data_area == MMRV_AREA_PROTECT); // RQ7
            data_tcall_q      <= core_data_req && (data_area == MMRV_AREA_TCALL); // RQ5
        end
    end
endmodule : mmrv_memory_map

// *** testbench/mmrv_flash_model.sv ***
// program flash model: synchronous byte reads of a fixed pattern
module mmrv_flash_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] flash_addr_q,
    output logic      [7:0]  flash_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // low and high byte of every pair differ, so a swapped vector shows
    always_ff @(posedge ref_clk) begin
        flash_rdata <= flash_addr_q[7:0] ^ 8'h5A;
    end
endmodule : mmrv_flash_model

// *** testbench/mmrv_memory_map_sva.sv ***
// checker: counter updates, vector loads and address decode of the memory map
module mmrv_memory_map_sva
    import mmrv_pkg::*;
#(
    parameter logic [15:0] FLASH_SIZE = MMRV_FLASH_2K
) (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        reset_pin_n,
    input wire logic        core_advance,
    input wire logic [2:0]  core_instr_len,
    input wire logic        core_branch,
    input wire logic        core_branch_sel_reg,
    input wire logic [15:0] core_branch_imm,
    input wire logic [15:0] core_branch_reg,
    input wire logic        core_vector_req,
    input wire logic        core_data_req,
    input wire logic [15:0] core_data_addr,
    input wire logic [15:0] pc_q,
    input wire logic        fetch_enable_q,
    input wire logic        vector_valid_q,
    input wire logic [15:0] vector_value_q,
    input wire logic        data_sel_flash_q,
    input wire logic        data_sel_ram_q,
    input wire logic        data_sel_sfr_q,
    input wire logic        data_prohibited_q,
    input wire logic        data_option_q,
    input wire logic        data_protect_q,
    input wire logic        data_tcall_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_go;
        fetch_enable_q && !core_vector_req;
    endsequence
    sequence s_vreq;
        fetch_enable_q && core_vector_req;
    endsequence
    property p_hold;
        (!reset_pin_n)[*5] |-> !fetch_enable_q;
    endproperty
    property p_adv;
        s_go ##0 (core_advance && !core_branch) |=>
            pc_q == $past(pc_q) + 16'($past(core_instr_len));
    endproperty
    property p_br;
        s_go ##0 core_branch |=> pc_q == ($past(core_branch_sel_reg) ?
            $past(core_branch_reg) : $past(core_branch_imm));
    endproperty
    property p_vec;
        s_vreq |-> ##[2:8] vector_valid_q;
    endproperty
    property p_vval;
        vector_valid_q |-> pc_q == vector_value_q;
    endproperty
    property p_flash;
        core_data_req && core_data_addr < FLASH_SIZE |=> data_sel_flash_q && !data_prohibited_q;
    endproperty
    property p_proh;
        core_data_req && core_data_addr >= FLASH_SIZE && core_data_addr < MMRV_RAM_BASE
            |=> data_prohibited_q && !data_sel_flash_q && !data_sel_ram_q;
    endproperty
    property p_ram;
        core_data_req && core_data_addr inside {[MMRV_RAM_BASE:MMRV_RAM_LAST]}
            |=> data_sel_ram_q && !data_sel_sfr_q;
    endproperty
    property p_sfr;
        core_data_req && core_data_addr >= MMRV_SFR_BASE |=> data_sel_sfr_q && !data_sel_ram_q;
    endproperty
    property p_tcall;
        core_data_req && core_data_addr inside {[MMRV_TCALL_BASE:MMRV_TCALL_LAST]}
            |=> data_tcall_q && !data_option_q;
    endproperty
    property p_opt;
        core_data_req && core_data_addr == MMRV_OPTION_ADDR |=> data_option_q && !data_protect_q;
    endproperty
    property p_prot;
        core_data_req && core_data_addr == MMRV_PROTECT_ADR |=> data_protect_q && !data_option_q;
    endproperty
    property p_idle;
        !core_data_req |=> !data_sel_flash_q && !data_sel_ram_q && !data_sel_sfr_q;
    endproperty
    a_hold: assert property (p_hold) else $error("fetch on while reset pin low");
    a_adv: assert property (p_adv) else $error("counter advance wrong");
    a_br: assert property (p_br) else $error("branch target wrong");
    a_vec: assert property (p_vec) else $error("vector load missing");
    a_vval: assert property (p_vval) else $error("counter not vector");
    a_flash: assert property (p_flash) else $error("flash decode wrong");
    a_proh: assert property (p_proh) else $error("gap decode wrong");
    a_ram: assert property (p_ram) else $error("ram decode wrong");
    a_sfr: assert property (p_sfr) else $error("register window decode wrong");
    a_tcall: assert property (p_tcall) else $error("table decode wrong");
    a_opt: assert property (p_opt) else $error("option decode wrong");
    a_prot: assert property (p_prot) else $error("protect decode wrong");
    a_idle: assert property (p_idle) else $error("flag without request");
endmodule : mmrv_memory_map_sva

bind mmrv_memory_map mmrv_memory_map_sva #(.FLASH_SIZE(FLASH_SIZE)) u_sva (.*);

// *** testbench/tb_top.sv ***
// testbench: reset vector, counter updates, vector loads and address decode
module tb_top import mmrv_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, reset_pin_n, core_advance, core_branch, core_branch_sel_reg;
    logic core_vector_req, core_data_req, flash_rd_q, fetch_enable_q, vector_valid_q;
    logic data_sel_flash_q, data_sel_ram_q, data_sel_sfr_q, data_prohibited_q;
    logic data_option_q, data_protect_q, data_tcall_q;
    logic [2:0]  core_instr_len;
    logic [7:0]  flash_rdata;
    logic [15:0] core_branch_imm, core_branch_reg, core_vector_addr, core_data_addr;
    logic [15:0] flash_addr_q, pc_q, vector_value_q;
    int          failures, num_checks;

    mmrv_memory_map #(.FLASH_SIZE(MMRV_FLASH_2K)) dut (.*);
    mmrv_flash_model flash (.*);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // vector expected from the model's pattern, low byte at the even address
    function automatic logic [15:0] rom16(input logic [15:0] a);
        return {(a[7:0] | 8'h01) ^ 8'h5A, (a[7:0] & 8'hFE) ^ 8'h5A};
    endfunction : rom16

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    task automatic wait_fetch();
        for (int n = 0; fetch_enable_q !== 1'b1; n++) begin
            if (n > 40) begin
                failures++;
                results();
            end
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_fetch

    task automatic t_pin();
        @(posedge ref_clk);
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk(16'(fetch_enable_q), 16'h0000, "fetch in hold");
        chk(pc_q, 16'h0000, "pc in hold");
        chk(16'(flash_rd_q), 16'h0000, "read in hold");
        @(posedge ref_clk);
        reset_pin_n <= 1'b1;
        #1;
        wait_fetch();
        chk(pc_q, rom16(16'h0000), "reset vector");
        chk(16'(flash_rd_q), 16'h0001, "read in run");
    endtask : t_pin

    task automatic t_adv();
        logic [15:0] p;
        for (int l = 1; l <= 4; l++) begin
            p = pc_q;
            @(posedge ref_clk);
            core_advance <= 1'b1;
            core_instr_len <= 3'(l);
            @(posedge ref_clk);
            core_advance <= 1'b0;
            #1;
            chk(pc_q, p + 16'(l), "advance");
        end
    endtask : t_adv

    // advance held high too: branch must win
    task automatic t_br(input logic sel, input logic [15:0] exp);
        @(posedge ref_clk);
        core_branch <= 1'b1;
        core_advance <= 1'b1;
        core_branch_sel_reg <= sel;
        @(posedge ref_clk);
        core_branch <= 1'b0;
        core_advance <= 1'b0;
        #1;
        chk(pc_q, exp, "branch");
    endtask : t_br

    task automatic t_vec();
        logic [15:0] slots [7] = '{16'h0006, 16'h0008, 16'h000B, 16'h000C,
                                   16'h000E, 16'h0010, 16'h0012};
        foreach (slots[i]) begin
            @(posedge ref_clk);
            core_vector_req <= 1'b1;
            core_vector_addr <= slots[i];
            @(posedge ref_clk);
            core_vector_req <= 1'b0;
            repeat (2) @(posedge ref_clk);
            #1;
            wait_fetch();
            chk(pc_q, rom16(slots[i]), "vector pc");
            chk(vector_value_q, rom16(slots[i]), "vector value");
        end
    endtask : t_vec

    task automatic t_data();
        logic [15:0] da [14] = '{16'h0000, 16'h0013, 16'h0040, 16'h007F, 16'h0080, 16'h0081,
            16'h0082, 16'h07FF, 16'h0800, 16'hFE7F, 16'hFE80, 16'hFEFF, 16'hFF00, 16'hFFFF};
        logic [6:0] df [14] = '{7'h40, 7'h40, 7'h41, 7'h41, 7'h44, 7'h42, 7'h40,
            7'h40, 7'h08, 7'h08, 7'h20, 7'h20, 7'h10, 7'h10};
        foreach (da[i]) begin
            @(posedge ref_clk);
            core_data_req <= 1'b1;
            core_data_addr <= da[i];
            @(posedge ref_clk);
            core_data_req <= 1'b0;
            #1;
            chk(16'({data_sel_flash_q, data_sel_ram_q, data_sel_sfr_q, data_prohibited_q,
                data_option_q, data_protect_q, data_tcall_q}), 16'(df[i]), "decode");
        end
    endtask : t_data

    initial begin
        {reset, reset_pin_n} = 2'b11;
        {core_advance, core_branch, core_branch_sel_reg, core_vector_req, core_data_req} = '0;
        core_instr_len = 3'h0;
        core_branch_imm = 16'h0123;
        core_branch_reg = 16'h0456;
        core_vector_addr = 16'h0000;
        core_data_addr = 16'h0000;
        failures = 0;
        num_checks = 0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        wait_fetch();
        chk(pc_q, rom16(16'h0000), "reset vector");
        t_pin();
        t_adv();
        t_br(1'b0, 16'h0123);
        t_br(1'b1, 16'h0456);
        t_vec();
        t_data();
        results();
    end
endmodule : tb_top
